// [hdl/npc_top.sv]
// Flash and EEPROM configuration and write-protection logic with an APB register slave.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`include "npc_map.svh"
`timescale 1ns/100ps
`default_nettype none

// The block sits between the processor and the nonvolatile array controller.
// Software reaches three byte registers over APB: configuration, protection and status.
// Every register answers with zero wait states; the answer is prepared in the setup cycle.
// Processor writes into the key window are steered either to the key comparator or to the
// command sequencer, depending on the key access bit.
// Every launched program or erase command is checked against the live protection value
// before it is allowed to run, and exactly one of go or ignored answers it one cycle later.
// The protection register starts from its reset value and takes the stored byte on the
// first edge after reset; until then software and debug writes to it and commands are not served.

module npc_top #(
  parameter int ADDR_W = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] storedProtectByte,
  input wire logic debugProtWrite,
  input wire logic [7:0] debugProtData,
  input wire logic memWrite,
  input wire logic [ADDR_W-1:0] memWrAddr,
  input wire logic [7:0] memWrData,
  output logic keyWrite,
  output logic [2:0] keyWrIndex,
  output logic [7:0] keyWrData,
  output logic cmdStart,
  output logic [ADDR_W-1:0] cmdStartAddr,
  output logic [7:0] cmdStartData,
  input wire logic cmdLaunch,
  input wire logic [7:0] cmdCode,
  input wire logic [ADDR_W-1:0] cmdAddr,
  output logic cmdGo,
  output logic cmdIgnored,
  output logic eepromPageSelect,
  output logic protectViolationFlag,
  output logic [7:0] protectRegister
);

  generate
    if (ADDR_W != 16) begin : gChk
      $error("npc_top serves a 16-bit address space only");
    end
  endgenerate

  // Register file and strobe state.
  npc_pkg::npc_byte_type config_ff, nxt_config;
  npc_pkg::npc_byte_type protect_ff, nxt_protect;
  logic viol_ff, nxt_viol;
  logic loaded_ff, nxt_loaded;
  npc_pkg::npc_word_type prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic keyWrite_ff, nxt_keyWrite;
  logic [2:0] keyIdx_ff, nxt_keyIdx;
  npc_pkg::npc_byte_type keyData_ff, nxt_keyData;
  logic cmdStart_ff, nxt_cmdStart;
  npc_pkg::npc_addr_type startAddr_ff, nxt_startAddr;
  npc_pkg::npc_byte_type startData_ff, nxt_startData;
  logic cmdGo_ff, nxt_cmdGo;
  logic cmdIgn_ff, nxt_cmdIgn;

  // Decode results.
  logic [1:0] eeprom_protect_select;
  logic [5:0] flash_protect_select;
  logic [5:0] fpsSteps;
  logic [16:0] flashStart;
  npc_pkg::npc_addr_type eeStart;
  logic eeAny;
  logic flashAny;
  logic addrProt;
  logic setup;
  logic access;
  logic mapped;
  logic [5:0] newFpsClamp;
  logic [5:0] oldFpsClamp;
  logic enlarges;
  npc_pkg::npc_byte_type wrByte;

  // Region decoding of the live protection value.
  // The decode is purely combinational on the register, so a write that enlarges protection
  // already guards the command launched in the very next cycle.
  always_comb begin
    eeprom_protect_select = protect_ff[`NPC_EPS_MSB:`NPC_EPS_LSB];
    flash_protect_select = protect_ff[`NPC_FPS_MSB:`NPC_FPS_LSB];
    eeAny = (eeprom_protect_select != `NPC_EPS_NONE);
    unique case (eeprom_protect_select)
      `NPC_EPS_SMALL: eeStart = `NPC_EE_START_SMALL;
      `NPC_EPS_MID: eeStart = `NPC_EE_START_MID;
      default: eeStart = `NPC_EE_START_LARGE;
    endcase
    flashAny = (flash_protect_select != `NPC_FPS_NONE);
    // Each step below the no-protection code, down to one above the floor, moves the flash start down by one step size.
    // The product is formed at 17 bits so that the top value NPC_FLASH_TOP of 10000 hex is still representable.
    fpsSteps = `NPC_FPS_NONE - flash_protect_select;
    if (flash_protect_select <= `NPC_FPS_FLOOR) begin
      flashStart = 17'h00000;
    end else begin
      flashStart = 17'(`NPC_FLASH_TOP - 17'(fpsSteps) * `NPC_FLASH_STEP);
    end
    // Both regions are tested for every command address before it may start.
    addrProt = (flashAny && ({1'b0, cmdAddr} >= flashStart)) ||
               (eeAny && (cmdAddr >= eeStart) && (cmdAddr <= `NPC_EE_END));
  end

  // Size comparison for software writes; all flash values at or below the floor cover the same region.
  always_comb begin
    // Only the low byte of the bus word carries register data; upper lanes are ignored.
    wrByte = pwdata[7:0];
    newFpsClamp = (wrByte[`NPC_FPS_MSB:`NPC_FPS_LSB] < `NPC_FPS_FLOOR) ? `NPC_FPS_FLOOR :
                  wrByte[`NPC_FPS_MSB:`NPC_FPS_LSB];
    oldFpsClamp = (flash_protect_select < `NPC_FPS_FLOOR) ? `NPC_FPS_FLOOR : flash_protect_select;
    // A write that shrinks either region is dropped as a whole, so the pair never moves apart.
    enlarges = (wrByte[`NPC_EPS_MSB:`NPC_EPS_LSB] <= eeprom_protect_select) && (newFpsClamp <= oldFpsClamp);
  end

  // Next-state logic for registers, bus answer and strobes.
  always_comb begin
    nxt_config = config_ff;
    nxt_protect = protect_ff;
    nxt_viol = viol_ff;
    nxt_loaded = 1'b1;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_keyWrite = 1'b0;
    nxt_keyIdx = keyIdx_ff;
    nxt_keyData = keyData_ff;
    nxt_cmdStart = 1'b0;
    nxt_startAddr = startAddr_ff;
    nxt_startData = startData_ff;
    nxt_cmdGo = 1'b0;
    nxt_cmdIgn = 1'b0;
    setup = psel && !penable;
    access = psel && penable && pready_ff;
    mapped = (paddr == `NPC_OFS_CONFIG) || (paddr == `NPC_OFS_PROTECT) || (paddr == `NPC_OFS_STATUS);

    // The answer is prepared in the setup cycle so that every bus output comes from a flop.
    if (setup) begin
      nxt_pready = 1'b1;
      nxt_pslverr = !mapped;
      nxt_prdata = 32'h00000000;
      if (!pwrite) begin
        unique case (paddr)
          `NPC_OFS_CONFIG: nxt_prdata = {24'h000000, config_ff};
          `NPC_OFS_PROTECT: nxt_prdata = {24'h000000, protect_ff};
          `NPC_OFS_STATUS: nxt_prdata = {26'h0000000, viol_ff, 5'h00};
          default: nxt_prdata = 32'h00000000;
        endcase
      end
    end

    if (access && pwrite && pstrb[0]) begin
      if (paddr == `NPC_OFS_CONFIG) begin
        nxt_config = 8'h00;
        nxt_config[`NPC_CFG_PAGE_BIT] = wrByte[`NPC_CFG_PAGE_BIT];
        nxt_config[`NPC_CFG_KEY_WRITE_ACCESS_BIT] = wrByte[`NPC_CFG_KEY_WRITE_ACCESS_BIT];
      end
      if ((paddr == `NPC_OFS_PROTECT) && loaded_ff && enlarges) begin
        nxt_protect = wrByte;
      end
      if ((paddr == `NPC_OFS_STATUS) && wrByte[`NPC_STAT_VIOL_BIT]) begin
        nxt_viol = 1'b0;
      end
    end

    // The debug path bypasses the size check and wins over a software write in the same cycle.
    // This lets a debugger lower protection, which software can never do by itself.
    if (debugProtWrite && loaded_ff) begin
      nxt_protect = debugProtData;
    end

    // The stored byte is copied once, on the first edge after reset is released.
    // It overrides both write paths, so nothing can slip in before the stored value lands.
    if (!loaded_ff) begin
      nxt_protect = storedProtectByte;
    end

    // Key window writes are served from the first edge after reset; they do not wait for the load.
    // Writes outside the window are not this block's business and leave every strobe low.
    if (memWrite && (memWrAddr >= `NPC_KEY_FIRST) && (memWrAddr <= `NPC_KEY_LAST)) begin
      if (config_ff[`NPC_CFG_KEY_WRITE_ACCESS_BIT]) begin
        nxt_keyWrite = 1'b1;
        nxt_keyIdx = memWrAddr[2:0];
        nxt_keyData = memWrData;
      end else begin
        nxt_cmdStart = 1'b1;
        nxt_startAddr = memWrAddr;
        nxt_startData = memWrData;
      end
    end

    // A refused command produces no go strobe at all, so the array never sees it.
    // Mass erase is refused when either region protects anything, whatever its address.
    if (cmdLaunch && loaded_ff) begin
      if (addrProt || ((cmdCode == `NPC_CMD_MASS_ERASE) && (eeAny || flashAny))) begin
        nxt_cmdIgn = 1'b1;
        // Setting comes last so a violation in the clearing cycle is kept.
        nxt_viol = 1'b1;
      end else begin
        nxt_cmdGo = 1'b1;
      end
    end
  end

  // All state is registered here; the reset branch loads constants only.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      config_ff <= `NPC_CFG_RESET;
      protect_ff <= `NPC_PROT_RESET;
      viol_ff <= 1'b0;
      loaded_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      keyWrite_ff <= 1'b0;
      keyIdx_ff <= 3'h0;
      keyData_ff <= 8'h00;
      cmdStart_ff <= 1'b0;
      startAddr_ff <= 16'h0000;
      startData_ff <= 8'h00;
      cmdGo_ff <= 1'b0;
      cmdIgn_ff <= 1'b0;
    end else begin
      config_ff <= nxt_config;
      protect_ff <= nxt_protect;
      viol_ff <= nxt_viol;
      loaded_ff <= nxt_loaded;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      keyWrite_ff <= nxt_keyWrite;
      keyIdx_ff <= nxt_keyIdx;
      keyData_ff <= nxt_keyData;
      cmdStart_ff <= nxt_cmdStart;
      startAddr_ff <= nxt_startAddr;
      startData_ff <= nxt_startData;
      cmdGo_ff <= nxt_cmdGo;
      cmdIgn_ff <= nxt_cmdIgn;
    end
  end

  // Every output is a plain copy of a flop, so no decode glitch reaches the pins.
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign keyWrite = keyWrite_ff;
  assign keyWrIndex = keyIdx_ff;
  assign keyWrData = keyData_ff;
  assign cmdStart = cmdStart_ff;
  assign cmdStartAddr = startAddr_ff;
  assign cmdStartData = startData_ff;
  assign cmdGo = cmdGo_ff;
  assign cmdIgnored = cmdIgn_ff;
  // The array maps only the selected page; the other page has no access path at all.
  assign eepromPageSelect = config_ff[`NPC_CFG_PAGE_BIT];
  assign protectViolationFlag = viol_ff;
  assign protectRegister = protect_ff;

endmodule

`default_nettype wire

// [hdl/npc_map.svh]
// Register offsets, field positions, reset values and decode constants of the protection block.
`ifndef NPC_MAP_SVH
`define NPC_MAP_SVH
`define NPC_OFS_CONFIG 12'h000
`define NPC_OFS_PROTECT 12'h004
`define NPC_OFS_STATUS 12'h008
`define NPC_CFG_PAGE_BIT 6
`define NPC_CFG_KEY_WRITE_ACCESS_BIT 5
`define NPC_STAT_VIOL_BIT 5
`define NPC_CFG_RESET 8'h00
`define NPC_PROT_RESET 8'hff
`define NPC_EPS_MSB 7
`define NPC_EPS_LSB 6
`define NPC_FPS_MSB 5
`define NPC_FPS_LSB 0
`define NPC_EPS_NONE 2'h3
`define NPC_EPS_SMALL 2'h2
`define NPC_EPS_MID 2'h1
`define NPC_EE_START_SMALL 16'h17f0
`define NPC_EE_START_MID 16'h17e0
`define NPC_EE_START_LARGE 16'h17c0
`define NPC_EE_END 16'h17ff
`define NPC_FPS_NONE 6'h3f
`define NPC_FPS_FLOOR 6'h18
`define NPC_FLASH_STEP 17'h00600
`define NPC_FLASH_TOP 17'h10000
`define NPC_KEY_FIRST 16'hffb0
`define NPC_KEY_LAST 16'hffb7
`define NPC_CMD_MASS_ERASE 8'h41
`endif

// [hdl/npc_pkg.sv]
// Shared types of the protection block.
package npc_pkg;
  typedef logic [7:0] npc_byte_type;
  typedef logic [15:0] npc_addr_type;
  typedef logic [31:0] npc_word_type;
endpackage

// [verif/npc_assertions.sv]
// Port-level checks of the protection block.
`timescale 1ns/100ps
`default_nettype none
module npc_assertions #(
  parameter int ADDR_W = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic debugProtWrite,
  input wire logic [7:0] debugProtData,
  input wire logic memWrite,
  input wire logic [ADDR_W-1:0] memWrAddr,
  input wire logic keyWrite,
  input wire logic [2:0] keyWrIndex,
  input wire logic cmdStart,
  input wire logic cmdLaunch,
  input wire logic [7:0] cmdCode,
  input wire logic cmdGo,
  input wire logic cmdIgnored,
  input wire logic eepromPageSelect,
  input wire logic protectViolationFlag,
  input wire logic [7:0] protectRegister
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic win;
  assign win = memWrite && memWrAddr[15:3] == 13'h1ff6;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_cfg_wr;
    psel && penable && pwrite && pstrb[0] && paddr == 12'h000;
  endsequence
  a_apb_ready: assert property (s_setup |=> pready) else $error("no ready");
  a_key_route: assert property (win |=> keyWrite != cmdStart) else $error("window lost");
  a_key_index: assert property (keyWrite |-> keyWrIndex == $past(memWrAddr[2:0])) else $error("index");
  a_one_answer: assert property (cmdLaunch && !$past(reset) |=> cmdGo != cmdIgnored) else $error("answer");
  a_ignore_flag: assert property (cmdIgnored |-> protectViolationFlag) else $error("flag");
  a_page_sel: assert property (s_cfg_wr |=> eepromPageSelect == $past(pwdata[6])) else $error("page");
  a_mass_refuse: assert property (cmdLaunch && cmdCode == 8'h41 && protectRegister != 8'hff && !$past(reset)
    |=> cmdIgnored) else $error("mass erase");
  a_debug_wr: assert property (debugProtWrite && !$past(reset) |=> protectRegister == $past(debugProtData))
    else $error("debug");
  a_no_shrink: assert property ($changed(protectRegister) && !$past(debugProtWrite) && !$past(reset)
    |-> protectRegister[7:6] <= $past(protectRegister[7:6])) else $error("shrink");
  a_no_fshrink: assert property ($changed(protectRegister) && !$past(debugProtWrite) && !$past(reset)
    |-> ((protectRegister[5:0] < 6'h18) ? 6'h18 : protectRegister[5:0]) <=
        (($past(protectRegister[5:0]) < 6'h18) ? 6'h18 : $past(protectRegister[5:0])))
    else $error("flash shrink");
endmodule
bind npc_top npc_assertions #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire

// [verif/npc_cpu_model.sv]
// Processor-side APB master model.
`timescale 1ns/100ps
`default_nettype none
module npc_cpu_model (
  input wire logic core_clk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  // The request stands until pready is seen; the bound keeps a dead slave from hanging the run.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // Ready is looked at mid-cycle, where it has settled, so the edge that takes it is never raced.
    @(negedge core_clk);
    while (!pready && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (!pready) tb_nvm_protection_config.stuck();
    @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/tb_nvm_protection_config.sv]
// Self-checking bench of the protection block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; $display("Error %0t %h %h", $time, a, e); end end
module tb_nvm_protection_config;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, debugProtWrite, memWrite, keyWrite, cmdStart;
  logic cmdLaunch, cmdGo, cmdIgnored, eepromPageSelect, protectViolationFlag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [3:0] pstrb;
  logic [2:0] keyWrIndex;
  logic [7:0] storedProtectByte, debugProtData, memWrData, keyWrData, cmdStartData, cmdCode, protectRegister;
  logic [15:0] memWrAddr, cmdStartAddr, cmdAddr;
  logic [32:0] expQ[$];
  int failures = 0;
  int n_compared = 0;
  npc_top uut (.*);
  npc_cpu_model cpu (.*);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task stuck;
    failures++;
    results();
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expQ.push_back(e);
    cpu.xfer(1'b0, a, 8'h00);
  endtask
  task automatic mw(input logic [15:0] a, input logic [7:0] d, input logic [32:0] e);
    expQ.push_back(e);
    @(posedge core_clk);
    memWrite <= 1'b1;
    memWrAddr <= a;
    memWrData <= d;
    @(posedge core_clk);
    memWrite <= 1'b0;
  endtask
  task automatic cl(input logic [7:0] c, input logic [15:0] a, input logic ign);
    expQ.push_back({32'h0, ign});
    @(posedge core_clk);
    cmdLaunch <= 1'b1;
    cmdCode <= c;
    cmdAddr <= a;
    @(posedge core_clk);
    cmdLaunch <= 1'b0;
  endtask
  // Every visible result takes the oldest note, so a missing or extra result shifts the queue and shows.
  // Outputs are looked at on the falling edge, half a cycle after they were launched.
  always @(negedge core_clk) begin
    logic [32:0] got, want;
    got = {21'h0, keyWrite, keyWrite ? keyWrIndex : cmdStartAddr[2:0], keyWrite ? keyWrData : cmdStartData};
    if (pready && !pwrite) got = {pslverr, prdata};
    if (cmdGo || cmdIgnored) got = {32'h0, cmdIgnored};
    if ((pready && !pwrite) || keyWrite || cmdStart || cmdGo || cmdIgnored) begin
      want = expQ.size() > 0 ? expQ.pop_front() : '1;
      `CHK(got, want)
    end
  end
  initial begin
    {reset, memWrite, cmdLaunch, debugProtWrite} = 4'hf;
    {memWrite, cmdLaunch, debugProtWrite} = 3'h0;
    {memWrAddr, memWrData, cmdCode, cmdAddr, debugProtData} = 56'h0;
    storedProtectByte = 8'h7e;
    seed = 32'hc;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(12'h004, 33'h7e);
    cpu.xfer(1'b1, 12'h000, 8'h60);
    rd(12'h000, 33'h60);
    mw(16'hffb3, 8'ha5, 33'hba5);
    cpu.xfer(1'b1, 12'h000, 8'h40);
    mw(16'hffb7, 8'h3c, 33'h73c);
    cl(8'h20, 16'h17df, 1'b0);
    cl(8'h40, 16'h17e0, 1'b1);
    cl(8'h25, 16'hf9ff, 1'b0);
    cl(8'h20, 16'hfa00, 1'b1);
    cl(8'h41, 16'h0000, 1'b1);
    rd(12'h008, 33'h20);
    cpu.xfer(1'b1, 12'h008, 8'h20);
    rd(12'h008, 33'h00);
    cpu.xfer(1'b1, 12'h004, 8'hbe);
    rd(12'h004, 33'h7e);
    cpu.xfer(1'b1, 12'h004, 8'h10);
    rd(12'h004, 33'h10);
    for (int i = 0; i < 4; i++) begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      cl(8'h20, seed[15:0], 1'b1);
    end
    rd(12'h00c, 33'h100000000);
    @(posedge core_clk);
    debugProtWrite <= 1'b1;
    debugProtData <= 8'hff;
    @(posedge core_clk);
    debugProtWrite <= 1'b0;
    rd(12'h004, 33'hff);
    cl(8'h41, 16'h0000, 1'b0);
    repeat (4) @(posedge core_clk);
    `CHK(expQ.size(), 0)
    results();
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    stuck();
  end
endmodule
`default_nettype wire
